// ---- pkg/ptmc_pkg.sv ----
// Register map, field positions and mode codes of the periodic timer control block.
package ptmc_pkg;

	localparam int CNT_W = 10;
	localparam logic [9:0] CNT_MAX = 10'h3ff;

	// Byte addresses of the registers on the AXI4-Lite slave.
	localparam logic [5:0] ADDR_RUN    = 6'h00;
	localparam logic [5:0] ADDR_MODE   = 6'h04;
	localparam logic [5:0] ADDR_CAPCLR = 6'h08;
	localparam logic [5:0] ADDR_CNTL   = 6'h0c;
	localparam logic [5:0] ADDR_CNTH   = 6'h10;
	localparam logic [5:0] ADDR_CMPAL  = 6'h14;
	localparam logic [5:0] ADDR_CMPAH  = 6'h18;
	localparam logic [5:0] ADDR_CMPBL  = 6'h1c;
	localparam logic [5:0] ADDR_CMPBH  = 6'h20;
	localparam logic [5:0] ADDR_PERL   = 6'h24;
	localparam logic [5:0] ADDR_PERH   = 6'h28;
	localparam logic [5:0] ADDR_FLAGS  = 6'h2c;

	// Field positions inside mode_output_control.
	localparam int MODE_HI = 7;
	localparam int MODE_LO = 6;
	localparam int PF_HI   = 5;
	localparam int PF_LO   = 4;
	localparam int OC_BIT  = 3;
	localparam int INV_BIT = 2;
	localparam int SRC_BIT = 1;
	localparam int CLA_BIT = 0;
	// Field positions inside capture_clear_control, run and flag registers.
	localparam int CC_HI   = 2;
	localparam int CC_LO   = 1;
	localparam int VLF_BIT = 0;
	localparam int RUN_BIT = 0;
	localparam int MAF_BIT = 0;
	localparam int MPF_BIT = 1;

	localparam logic [7:0] CTRL_RESET = 8'h00;

	typedef enum logic [1:0] {
		PTMC_COMPARE = 2'b00,
		PTMC_CAPTURE = 2'b01,
		PTMC_PWM     = 2'b10,
		PTMC_TIMER   = 2'b11
	} ptmc_mode_t;

	localparam logic [1:0] PF_00 = 2'b00;
	localparam logic [1:0] PF_01 = 2'b01;
	localparam logic [1:0] PF_10 = 2'b10;
	localparam logic [1:0] PF_11 = 2'b11;

endpackage : ptmc_pkg

// ---- src/ptmc_timer.sv ----
// Periodic timer control, capture and compare-match block with an AXI4-Lite register slave.
`timescale 1ns/1ps

module ptmc_timer #(
	parameter int CNT_W = ptmc_pkg::CNT_W
) (
	input  wire logic        ref_clk,
	input  wire logic        rstn,
	input  wire logic [5:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [5:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        capture_input_pin,
	input  wire logic        external_clock_pin,
	output logic             timer_output_pin,
	output logic             timer_output_oe
);

	// Comparators, byte lanes and the read mux are laid out for a ten-bit count only.
	if (CNT_W != ptmc_pkg::CNT_W) begin : g_cntWidthCheck
		$error("Counter width other than ten bits is not supported.");
	end

	////////////////////////////////////////////////////////////////////////////////
	// Register state.
	logic [7:0]  modeCtrl_reg;
	logic [1:0]  capClr_reg;
	logic        latchEdge_reg;
	logic        run_reg;
	logic        runDly_reg;
	logic [9:0]  cmpA_reg;
	logic [9:0]  cmpB_reg;
	logic [9:0]  period_reg;
	logic [9:0]  count_reg;
	logic        outLvl_reg;
	logic        flagA_reg;
	logic        flagP_reg;
	logic [2:0]  capSync_reg;
	logic        capPrev_reg;
	logic [5:0]  awAddr_reg;
	logic        awHave_reg;
	logic [31:0] wData_reg;
	logic [3:0]  wStrb_reg;
	logic        wHave_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Field decode.
	wire ptmc_pkg::ptmc_mode_t mode = ptmc_pkg::ptmc_mode_t'(
		modeCtrl_reg[ptmc_pkg::MODE_HI:ptmc_pkg::MODE_LO]);
	wire [1:0] pinFunc   = modeCtrl_reg[ptmc_pkg::PF_HI:ptmc_pkg::PF_LO];
	wire       initLvl   = modeCtrl_reg[ptmc_pkg::OC_BIT];
	wire       invert    = modeCtrl_reg[ptmc_pkg::INV_BIT];
	wire       srcSel    = modeCtrl_reg[ptmc_pkg::SRC_BIT];
	wire       clearOnA  = modeCtrl_reg[ptmc_pkg::CLA_BIT];
	wire       isCompare = (mode == ptmc_pkg::PTMC_COMPARE) || (mode == ptmc_pkg::PTMC_TIMER);
	wire       isCapture = mode == ptmc_pkg::PTMC_CAPTURE;
	wire       isPwm     = mode == ptmc_pkg::PTMC_PWM;
	wire       runRise   = run_reg && !runDly_reg;

	////////////////////////////////////////////////////////////////////////////////
	// Capture input: three flops, a change counts once the last two agree.
	wire capRaw  = srcSel ? external_clock_pin : capture_input_pin;
	wire capStab = capSync_reg[2] == capSync_reg[1];
	wire capRise = capStab && capSync_reg[2] && !capPrev_reg;
	wire capFall = capStab && !capSync_reg[2] && capPrev_reg;

	// Capture routing by pin function and capture-clear code.
	wire capOff   = pinFunc == ptmc_pkg::PF_11;
	wire riseSel  = (pinFunc == ptmc_pkg::PF_00) || (pinFunc == ptmc_pkg::PF_10);
	wire fallSel  = (pinFunc == ptmc_pkg::PF_01) || (pinFunc == ptmc_pkg::PF_10);
	wire capRun   = isCapture && run_reg && !capOff;
	wire capRiseA = capRun && capRise && riseSel && (capClr_reg == ptmc_pkg::PF_00);
	wire capRiseB = capRun && capRise && riseSel && (capClr_reg != ptmc_pkg::PF_00);
	wire capFallA = capRun && capFall && fallSel;
	wire capAny   = capRiseA || capRiseB || capFallA;

	////////////////////////////////////////////////////////////////////////////////
	// Comparators and clear conditions.
	wire matchA   = run_reg && (count_reg == cmpA_reg) && (cmpA_reg != '0);
	wire matchP   = run_reg && (count_reg == period_reg) && (period_reg != '0);
	wire overflow = run_reg && (count_reg == ptmc_pkg::CNT_MAX);
	wire useA     = isCompare && clearOnA;
	wire edgeClr  = isCapture && run_reg && (
		((capClr_reg == ptmc_pkg::PF_01) && capRise) ||
		((capClr_reg == ptmc_pkg::PF_10) && capFall) ||
		((capClr_reg == ptmc_pkg::PF_11) && (capRise || capFall)));
	wire pulseEnd = isPwm && (pinFunc == ptmc_pkg::PF_11) && matchA;
	wire clrCnt   = useA ? matchA : (matchP || edgeClr || overflow);
	wire setFlagA = matchA && !isCapture;
	wire setFlagP = matchP && !useA;

	// Counter; it only runs while run is high and restarts from zero on a run rise.
	wire [9:0] countNext = runRise ? '0 :
		!run_reg ? count_reg :
		(clrCnt && !isPwm) || (isPwm && matchP) ? '0 :
		(isPwm && pinFunc == ptmc_pkg::PF_11 && matchA) ? count_reg :
		count_reg + 10'h001;

	// Compare-mode output level.
	wire cmpLvl = (pinFunc == ptmc_pkg::PF_01) ? 1'b0 :
		(pinFunc == ptmc_pkg::PF_10) ? 1'b1 :
		(pinFunc == ptmc_pkg::PF_11) ? !outLvl_reg : outLvl_reg;
	wire outNext = runRise ? initLvl :
		(mode == ptmc_pkg::PTMC_COMPARE && setFlagA) ? cmpLvl : outLvl_reg;

	// PWM / single pulse output: PWM (pin function 10) is active while count is below compare A, single pulse while run is high.
	wire pwmActive = (pinFunc == ptmc_pkg::PF_01) ||
		((pinFunc == ptmc_pkg::PF_10) && run_reg &&
		 ((count_reg < cmpA_reg) || (period_reg != '0 && cmpA_reg >= period_reg))) ||
		((pinFunc == ptmc_pkg::PF_11) && run_reg);
	wire pwmLvl   = pwmActive ? initLvl : !initLvl;
	wire pinPre   = isPwm ? pwmLvl : outLvl_reg;
	// The pin follows the output only in modes that drive it, so it never shows a level
	// while its enable is low; both leave through flops on the same edge.
	wire oeNext   = (mode != ptmc_pkg::PTMC_TIMER) && (mode != ptmc_pkg::PTMC_CAPTURE);
	wire pinNext  = oeNext ? (pinPre ^ invert) : 1'b0;

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write path; address and data are taken in either order.
	wire awTake  = s_axi_awvalid && s_axi_awready;
	wire wTake   = s_axi_wvalid && s_axi_wready;
	wire doWrite = awHave_reg && wHave_reg && !s_axi_bvalid;
	wire [7:0] wb = wData_reg[7:0];
	wire wLane  = wStrb_reg[0];
	wire wrRun  = doWrite && wLane && (awAddr_reg == ptmc_pkg::ADDR_RUN);
	wire wrMode = doWrite && wLane && (awAddr_reg == ptmc_pkg::ADDR_MODE);
	wire wrCc   = doWrite && wLane && (awAddr_reg == ptmc_pkg::ADDR_CAPCLR);
	wire wrAL   = doWrite && wLane && (awAddr_reg == ptmc_pkg::ADDR_CMPAL);
	wire wrAH   = doWrite && wLane && (awAddr_reg == ptmc_pkg::ADDR_CMPAH);
	wire wrBL   = doWrite && wLane && (awAddr_reg == ptmc_pkg::ADDR_CMPBL);
	wire wrBH   = doWrite && wLane && (awAddr_reg == ptmc_pkg::ADDR_CMPBH);
	wire wrPL   = doWrite && wLane && (awAddr_reg == ptmc_pkg::ADDR_PERL);
	wire wrPH   = doWrite && wLane && (awAddr_reg == ptmc_pkg::ADDR_PERH);
	wire wrFlg  = doWrite && wLane && (awAddr_reg == ptmc_pkg::ADDR_FLAGS);
	wire wMapped = (awAddr_reg <= ptmc_pkg::ADDR_FLAGS) && (awAddr_reg[1:0] == 2'b00) &&
		(awAddr_reg != ptmc_pkg::ADDR_CNTL) && (awAddr_reg != ptmc_pkg::ADDR_CNTH);

	// Single pulse ends by dropping run on an A match; a software write in the same edge wins.
	wire runNext = wrRun ? wb[ptmc_pkg::RUN_BIT] : (pulseEnd ? 1'b0 : run_reg);

	// Flags are cleared by writing one; a hardware set in the same edge wins.
	wire flagANext = setFlagA || (flagA_reg && !(wrFlg && wb[ptmc_pkg::MAF_BIT]));
	wire flagPNext = setFlagP || (flagP_reg && !(wrFlg && wb[ptmc_pkg::MPF_BIT]));

	wire [9:0] cmpANext = capFallA || capRiseA ? count_reg :
		{wrAH ? wb[1:0] : cmpA_reg[9:8], wrAL ? wb : cmpA_reg[7:0]};
	wire [9:0] cmpBNext = capRiseB ? count_reg :
		{wrBH ? wb[1:0] : cmpB_reg[9:8], wrBL ? wb : cmpB_reg[7:0]};
	wire [9:0] periodNext = {wrPH ? wb[1:0] : period_reg[9:8], wrPL ? wb : period_reg[7:0]};

	////////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read path.
	wire [5:0] ra = s_axi_araddr;
	wire [7:0] rdByte =
		(ra == ptmc_pkg::ADDR_RUN)    ? {7'h00, run_reg} :
		(ra == ptmc_pkg::ADDR_MODE)   ? modeCtrl_reg :
		(ra == ptmc_pkg::ADDR_CAPCLR) ? {5'h00, capClr_reg, latchEdge_reg} :
		(ra == ptmc_pkg::ADDR_CNTL)   ? count_reg[7:0] :
		(ra == ptmc_pkg::ADDR_CNTH)   ? {6'h00, count_reg[9:8]} :
		(ra == ptmc_pkg::ADDR_CMPAL)  ? cmpA_reg[7:0] :
		(ra == ptmc_pkg::ADDR_CMPAH)  ? {6'h00, cmpA_reg[9:8]} :
		(ra == ptmc_pkg::ADDR_CMPBL)  ? cmpB_reg[7:0] :
		(ra == ptmc_pkg::ADDR_CMPBH)  ? {6'h00, cmpB_reg[9:8]} :
		(ra == ptmc_pkg::ADDR_PERL)   ? period_reg[7:0] :
		(ra == ptmc_pkg::ADDR_PERH)   ? {6'h00, period_reg[9:8]} :
		(ra == ptmc_pkg::ADDR_FLAGS)  ? {6'h00, flagP_reg, flagA_reg} : 8'h00;
	wire rMapped = (ra <= ptmc_pkg::ADDR_FLAGS) && (ra[1:0] == 2'b00);
	wire arTake  = s_axi_arvalid && s_axi_arready;

	assign s_axi_awready = !awHave_reg && !s_axi_bvalid;
	assign s_axi_wready  = !wHave_reg && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	////////////////////////////////////////////////////////////////////////////////
	// Bus handshake state.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			awHave_reg <= 1'b0;
			wHave_reg  <= 1'b0;
			awAddr_reg <= 6'h00;
			wData_reg  <= 32'h00000000;
			wStrb_reg  <= 4'h0;
		end else begin
			if (awTake) begin
				awAddr_reg <= s_axi_awaddr;
			end
			if (wTake) begin
				wData_reg <= s_axi_wdata;
				wStrb_reg <= s_axi_wstrb;
			end
			awHave_reg <= doWrite ? 1'b0 : (awHave_reg || awTake);
			wHave_reg  <= doWrite ? 1'b0 : (wHave_reg || wTake);
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'b00;
		end else if (doWrite) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wMapped ? 2'b00 : 2'b10;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h00000000;
			s_axi_rresp  <= 2'b00;
		end else if (arTake) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= {24'h000000, rdByte};
			s_axi_rresp  <= rMapped ? 2'b00 : 2'b10;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Control registers and timer core.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			modeCtrl_reg <= ptmc_pkg::CTRL_RESET;
			capClr_reg   <= 2'b00;
			run_reg      <= 1'b0;
			runDly_reg   <= 1'b0;
		end else begin
			if (wrMode) begin
				modeCtrl_reg <= wb;
			end
			if (wrCc) begin
				capClr_reg <= wb[ptmc_pkg::CC_HI:ptmc_pkg::CC_LO];
			end
			run_reg    <= runNext;
			runDly_reg <= run_reg;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			count_reg <= 10'h000;
		end else begin
			count_reg <= countNext;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cmpA_reg <= 10'h000;
		end else begin
			cmpA_reg <= cmpANext;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			cmpB_reg <= 10'h000;
		end else begin
			cmpB_reg <= cmpBNext;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			period_reg <= 10'h000;
		end else begin
			period_reg <= periodNext;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			outLvl_reg <= 1'b0;
		end else begin
			outLvl_reg <= outNext;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			timer_output_pin <= 1'b0;
		end else begin
			timer_output_pin <= pinNext;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			timer_output_oe <= 1'b0;
		end else begin
			timer_output_oe <= oeNext;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			flagA_reg <= 1'b0;
		end else begin
			flagA_reg <= flagANext;
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			flagP_reg <= 1'b0;
		end else begin
			flagP_reg <= flagPNext;
		end
	end

	// The first stage is read only by the second, so a metastable level never fans out.
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			capSync_reg <= 3'b000;
		end else begin
			capSync_reg <= {capSync_reg[1:0], capRaw};
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			capPrev_reg <= 1'b0;
		end else if (capStab) begin
			capPrev_reg <= capSync_reg[2];
		end
	end

	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			latchEdge_reg <= 1'b0;
		end else if (capAny) begin
			latchEdge_reg <= capRiseA || capRiseB;
		end
	end

endmodule : ptmc_timer

// ---- dv/ptmc_timer_asserts.sv ----
// Checker on the ports of the periodic timer block.
`timescale 1ns/1ps
////////////////////////////////////////
module ptmc_timer_asserts (
	input wire logic        ref_clk,
	input wire logic        rstn,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        timer_output_pin,
	input wire logic        timer_output_oe
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);
	a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
	a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
	a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
	a_read_late: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read data late");
	a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while busy");
	a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("unused read bits not zero");
	a_resp_code: assert property (s_axi_bvalid |-> !s_axi_bresp[0])
		else $error("bad write response code");
	a_timer_pin: assert property (!timer_output_oe |-> !timer_output_pin)
		else $error("pin active while not driven");
endmodule : ptmc_timer_asserts

// ---- dv/ptmc_pin_model.sv ----
// Model of the capture sources and the load on the timer output pin.
`timescale 1ns/1ps
////////////////////////////////////////
module ptmc_pin_model (
	input  wire logic ref_clk,
	input  wire logic capLevel,
	input  wire logic extLevel,
	input  wire logic timer_output_pin,
	output logic      capture_input_pin,
	output logic      external_clock_pin,
	output int        riseCount
);
	logic lastPin;
	initial {capture_input_pin, external_clock_pin, lastPin} = 3'b000;
	// Edges leave on a clock edge so the synchroniser delay seen by the bench is fixed.
	always @(posedge ref_clk) begin
		capture_input_pin <= capLevel;
		external_clock_pin <= extLevel;
		lastPin <= timer_output_pin;
		if (timer_output_pin && !lastPin)
			riseCount <= riseCount + 1;
	end
endmodule : ptmc_pin_model

// ---- dv/tb_top.sv ----
// Self-checking bench of the periodic timer block.
`timescale 1ns/1ps
////////////////////////////////////////
module tb_top;
	logic        ref_clk, rstn, capLevel, extLevel, clr;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, timer_output_pin, timer_output_oe;
	logic        capture_input_pin, external_clock_pin;
	logic [5:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, lastResp;
	logic [7:0]  rdByte, held;
	logic [4:0]  cmpCase [5] = '{5'h05, 5'h0c, 5'h11, 5'h1c, 5'h12};
	logic [8:0]  capCase [10] = '{9'h006, 9'h022, 9'h042, 9'h064, 9'h015, 9'h052, 9'h02a,
		9'h186, 9'h084, 9'h01d};
	int          err_total, tests_run, riseCount, n0;
	ptmc_timer i_dut (.ref_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .capture_input_pin, .external_clock_pin,
		.timer_output_pin, .timer_output_oe);
	ptmc_pin_model i_pins (.ref_clk, .capLevel, .extLevel, .timer_output_pin,
		.capture_input_pin, .external_clock_pin, .riseCount);
	initial ref_clk = 1'b0;
	always #20 ref_clk = ~ref_clk;
	////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// Ready is sampled at the edge, so each valid drops only after its own handshake.
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		do begin
			@(posedge ref_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		lastResp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [5:0] a);
		@(posedge ref_clk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'b11;
		do begin
			@(posedge ref_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rdByte = s_axi_rdata[7:0];
		lastResp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : rd
	task automatic rdchk(input logic [5:0] a, input logic [7:0] e);
		rd(a);
		chk(rdByte, e);
	endtask : rdchk
	task automatic cfg(input logic [7:0] m, input logic [9:0] a, input logic [9:0] p);
		wr(ptmc_pkg::ADDR_RUN, 8'h00);
		wr(ptmc_pkg::ADDR_MODE, m);
		wr(ptmc_pkg::ADDR_CMPAL, a[7:0]);
		wr(ptmc_pkg::ADDR_CMPAH, {6'h00, a[9:8]});
		wr(ptmc_pkg::ADDR_PERL, p[7:0]);
		wr(ptmc_pkg::ADDR_PERH, {6'h00, p[9:8]});
		wr(ptmc_pkg::ADDR_FLAGS, 8'h03);
		wr(ptmc_pkg::ADDR_RUN, 8'h01);
	endtask : cfg
	////////////////////////////////////////
	task automatic t_regs();
		for (int i = 0; i < 12; i++) begin
			rdchk(6'(i * 4), 8'h00);
			chk(lastResp, 2'b00);
		end
		rd(6'h30);
		chk(lastResp, 2'b10);
		wr(ptmc_pkg::ADDR_CNTH, 8'h03);
		chk(lastResp, 2'b10);
		for (int i = 5; i < 11; i++) begin
			wr(6'(i * 4), 8'hff);
			rdchk(6'(i * 4), (i % 2) ? 8'hff : 8'h03);
		end
		wr(ptmc_pkg::ADDR_MODE, 8'ha5);
		rdchk(ptmc_pkg::ADDR_MODE, 8'ha5);
		wr(ptmc_pkg::ADDR_CAPCLR, 8'hff);
		rdchk(ptmc_pkg::ADDR_CAPCLR, 8'h06);
	endtask : t_regs
	task automatic t_compare();
		for (int i = 0; i < 5; i++) begin
			cfg({2'b00, cmpCase[i][4:1], 2'b00}, 10'd40, 10'd0);
			repeat (2) @(posedge ref_clk);
			chk(timer_output_pin, cmpCase[i][2] ^ cmpCase[i][1]);
			chk(timer_output_oe, 1'b1);
			repeat (60) @(posedge ref_clk);
			chk(timer_output_pin, cmpCase[i][0]);
			rdchk(ptmc_pkg::ADDR_FLAGS, 8'h01);
			wr(ptmc_pkg::ADDR_RUN, 8'h00);
			wr(ptmc_pkg::ADDR_RUN, 8'h01);
			repeat (2) @(posedge ref_clk);
			chk(timer_output_pin, cmpCase[i][2] ^ cmpCase[i][1]);
		end
	endtask : t_compare
	task automatic t_flags();
		cfg(8'h00, 10'd10, 10'd30);
		repeat (100) @(posedge ref_clk);
		rdchk(ptmc_pkg::ADDR_FLAGS, 8'h03);
		cfg(8'h01, 10'd10, 10'd5);
		repeat (100) @(posedge ref_clk);
		rdchk(ptmc_pkg::ADDR_FLAGS, 8'h01);
		rd(ptmc_pkg::ADDR_CNTL);
		chk(rdByte <= 8'd10, 1'b1);
		cfg(8'h00, 10'd0, 10'd0);
		repeat (300) @(posedge ref_clk);
		rdchk(ptmc_pkg::ADDR_FLAGS, 8'h00);
		rdchk(ptmc_pkg::ADDR_CNTH, 8'h01);
		wr(ptmc_pkg::ADDR_RUN, 8'h00);
		rd(ptmc_pkg::ADDR_CNTL);
		held = rdByte;
		repeat (20) @(posedge ref_clk);
		rdchk(ptmc_pkg::ADDR_CNTL, held);
		wr(ptmc_pkg::ADDR_RUN, 8'h01);
		rd(ptmc_pkg::ADDR_CNTL);
		chk(rdByte < 8'd8, 1'b1);
	endtask : t_flags
	// Stop first so a stale edge cannot land in the freshly cleared capture registers.
	task automatic t_capture();
		for (int i = 0; i < 10; i++) begin
			wr(ptmc_pkg::ADDR_RUN, 8'h00);
			{capLevel, extLevel} <= {2{!capCase[i][2]}};
			wr(ptmc_pkg::ADDR_CAPCLR, {5'h00, capCase[i][4:3], 1'b0});
			wr(ptmc_pkg::ADDR_CMPBL, 8'h00);
			cfg({2'b01, capCase[i][6:5], 2'b00, capCase[i][8], 1'b0}, 10'd0, 10'd0);
			repeat (40) @(posedge ref_clk);
			if (capCase[i][7]) extLevel <= capCase[i][2];
			else capLevel <= capCase[i][2];
			repeat (12) @(posedge ref_clk);
			wr(ptmc_pkg::ADDR_RUN, 8'h00);
			rd(ptmc_pkg::ADDR_CMPAL);
			chk(rdByte != 8'h00, capCase[i][1]);
			rd(ptmc_pkg::ADDR_CMPBL);
			chk(rdByte != 8'h00, capCase[i][0]);
			clr = capCase[i][4:3] == 2'b11 || capCase[i][4:3] == {!capCase[i][2], capCase[i][2]};
			rd(ptmc_pkg::ADDR_CNTL);
			chk(rdByte < 8'd30, clr);
			rd(ptmc_pkg::ADDR_CAPCLR);
			if (capCase[i][4:3] != 2'b00) chk(rdByte[0], capCase[i][2]);
		end
	endtask : t_capture
	task automatic t_modes();
		cfg(8'h88, 10'd5, 10'd20);
		repeat (3) @(posedge ref_clk);
		chk(timer_output_pin, 1'b0);
		cfg(8'h98, 10'd5, 10'd20);
		repeat (3) @(posedge ref_clk);
		chk(timer_output_pin, 1'b1);
		n0 = riseCount;
		cfg(8'ha9, 10'd5, 10'd20);
		repeat (100) @(posedge ref_clk);
		n0 = riseCount - n0;
		chk(n0 >= 4 && n0 <= 6, 1'b1);
		cfg(8'hb8, 10'd10, 10'd0);
		repeat (40) @(posedge ref_clk);
		rdchk(ptmc_pkg::ADDR_RUN, 8'h00);
		chk(timer_output_pin, 1'b0);
		cfg(8'hc0, 10'd0, 10'd0);
		repeat (3) @(posedge ref_clk);
		chk(timer_output_oe, 1'b0);
	endtask : t_modes
	task automatic give_verdict();
		if (err_total == 0 && tests_run > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : give_verdict
	initial begin
		{rstn, capLevel, extLevel, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'h1;
		repeat (16) @(posedge ref_clk);
		rstn <= 1'b1;
		t_regs();
		t_compare();
		t_flags();
		t_capture();
		t_modes();
		give_verdict();
	end
	initial begin
		#400000;
		err_total++;
		give_verdict();
	end
endmodule : tb_top
bind ptmc_timer ptmc_timer_asserts i_chk (.ref_clk, .rstn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
	.timer_output_pin, .timer_output_oe);
